// file: logic/otp_store_pkg.sv
/*
 * Shared constants and types for the one-time-programmable parameter store:
 * fuse byte map, field positions, lock masks, timing counts, carriers.
 * Assumes a 40 MHz system clock.
 */
package otp_store_pkg;

	// array geometry
	localparam int FUSE_BYTES = 10;
	localparam int FUSE_WIDTH = 8;
	localparam int FUSE_BITS  = FUSE_BYTES * FUSE_WIDTH;

	// fuse byte offsets
	localparam logic [3:0] OTP_CALIB_TRIM_A          = 4'h0;
	localparam logic [3:0] OTP_BUS_CONFIG_TRIM       = 4'h1;
	localparam logic [3:0] OTP_STALL_NODE_CFG        = 4'h2;
	localparam logic [3:0] OTP_COIL_CURRENT_CFG      = 4'h3;
	localparam logic [3:0] OTP_SPEED_CFG             = 4'h4;
	localparam logic [3:0] OTP_SAFE_POS_HI_RAMP      = 4'h5;
	localparam logic [3:0] OTP_SAFE_POS_LO_FLAGS     = 4'h6;
	localparam logic [3:0] OTP_UNDERVOLT_STEP_LOCK   = 4'h7;
	localparam logic [3:0] OTP_ALT_SAFE_POS_HI_CLK   = 4'h8;
	localparam logic [3:0] OTP_ALT_SAFE_POS_LO_FLAGS = 4'h9;

	// field positions (lsb) inside their bytes
	localparam int BANK_SEL_BIT     = 7;
	localparam int THERMAL_LSB      = 4;
	localparam int CURREF_LSB       = 0;
	localparam int BAUD_BIT         = 7;
	localparam int COMBINE_BIT      = 6;
	localparam int BANDGAP_LSB      = 0;
	localparam int STALL_LSB        = 4;
	localparam int NODE_LSB         = 0;
	localparam int RUN_LSB          = 4;
	localparam int HOLD_LSB         = 0;
	localparam int VMAX_LSB         = 4;
	localparam int VMIN_LSB         = 0;
	localparam int SAFE_HI_LSB      = 5;
	localparam int SHAFT_BIT        = 4;
	localparam int ACC_LSB          = 0;
	localparam int SAFE_LO_LSB      = 2;
	localparam int FAILSAFE_BIT     = 1;
	localparam int SLEEP_BIT        = 0;
	localparam int UV_FILTER_BIT    = 7;
	localparam int UV_LEVEL_LSB     = 4;
	localparam int STEP_LSB         = 2;
	localparam int TRIM_LOCK_BIT    = 1;
	localparam int GLOBAL_LOCK_BIT  = 0;
	localparam int CLOCK_TRIM_LSB   = 0;

	// bits left open to zapping while the factory lock is set
	localparam logic [7:0] TRIM_LOCK_KEEP_0 = 8'h80;
	localparam logic [7:0] TRIM_LOCK_KEEP_1 = 8'hc0;
	localparam logic [7:0] TRIM_LOCK_KEEP_8 = 8'he0;

	// upper nine bits of the secure position that disable it
	localparam logic [8:0] SAFE_POS_OFF_PATTERN = 9'h100;
	localparam logic [3:0] HOLD_ZERO_INDEX      = 4'hf;
	localparam logic [3:0] LOWEST_LEVEL_INDEX   = 4'h0;
	localparam logic [4:0] MICROSTEP_BASE       = 5'h02;

	// delivery image: only the factory trim lock bit set
	localparam logic [FUSE_BITS-1:0] FACTORY_IMAGE =
		80'h0000_0200_0000_0000_0000;

	// timing
	localparam int CLK_PERIOD_NS   = 25;
	localparam int ZAP_PULSE_NS    = 1000;
	localparam int ZAP_CYCLES      =
		(ZAP_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int HOLD_SETTLE_NS  = 1000;
	localparam int HOLD_SETTLE_CYC =
		(HOLD_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef struct packed {
		logic [3:0]  run_current;
		logic [3:0]  hold_current;
		logic [3:0]  max_velocity;
		logic [3:0]  min_velocity;
		logic        shaft_dir;
		logic [3:0]  accel;
		logic [10:0] safe_target_position;
		logic [1:0]  microstep_resolution;
		logic [3:0]  stall_emf_threshold;
		logic        fail_safe;
		logic        auto_sleep_allow;
		logic [2:0]  undervolt_level_sel;
		logic        undervolt_recover_filter;
	} motion_cfg_type;

	typedef struct packed {
		logic [2:0] thermal_trip_trim;
		logic [3:0] current_reference_trim;
		logic [5:0] bandgap_trim;
		logic [4:0] clock_trim;
		logic       bus_baud_select;
		logic       node_id_combine_sel;
	} trim_type;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] data;
	} fuse_req_type;

endpackage

// file: logic/fuse_array.sv
/*
 * Ten-byte fuse array model. Bits only ever go from zero to one.
 * Assumes the caller presents a single zap strobe per burned byte.
 */
`timescale 1ns/1ps
module fuse_array #(
	parameter int BYTES = otp_store_pkg::FUSE_BYTES,
	parameter int WIDTH = otp_store_pkg::FUSE_WIDTH
) (
	// clock
	input  wire logic                   clk_in,
	// zap port
	input  wire logic                   zap_in,
	input  wire logic [3:0]             zap_addr_in,
	input  wire logic [WIDTH-1:0]       zap_mask_in,
	// contents
	output logic      [BYTES*WIDTH-1:0] image_out
);
	import otp_store_pkg::*;

	// zapped bits only; nonvolatile, so reset leaves them alone
	logic [WIDTH-1:0] cell_q [BYTES] = '{default: '0};

	always_ff @(posedge clk_in) begin
		if (zap_in && (int'(zap_addr_in) < BYTES)) begin
			cell_q[zap_addr_in] <= cell_q[zap_addr_in] | zap_mask_in;
		end
	end

	always_comb begin
		for (int i = 0; i < BYTES; i++) begin
			image_out[i*WIDTH +: WIDTH] = FACTORY_IMAGE[i*WIDTH +: WIDTH] |
				cell_q[i];
		end
	end

endmodule

// file: logic/current_hold_seq.sv
/*
 * Coil current level sequencer between run and hold levels.
 * Assumes motion_running_in is a level from the motion controller.
 */
`timescale 1ns/1ps
module current_hold_seq #(
	parameter int SETTLE_CYCLES = otp_store_pkg::HOLD_SETTLE_CYC
) (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       resetn_in,
	// levels
	input  wire logic       running_in,
	input  wire logic [3:0] run_idx_in,
	input  wire logic [3:0] hold_idx_in,
	// drive
	output logic      [3:0] level_out,
	output logic            regulator_off_out,
	output logic            low_side_ground_out
);
	import otp_store_pkg::*;

	logic [11:0] settle_q;

	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			level_out           <= LOWEST_LEVEL_INDEX;
			regulator_off_out   <= 1'b0;
			low_side_ground_out <= 1'b0;
			settle_q            <= 12'h000;
		end else if (running_in) begin
			level_out           <= run_idx_in;
			regulator_off_out   <= 1'b0;
			low_side_ground_out <= 1'b0;
			settle_q            <= 12'h000;
		end else if (hold_idx_in != HOLD_ZERO_INDEX) begin
			level_out           <= hold_idx_in;
			regulator_off_out   <= 1'b0;
			low_side_ground_out <= 1'b0;
			settle_q            <= 12'h000;
		end else begin
			level_out <= LOWEST_LEVEL_INDEX;
			if (settle_q == 12'(SETTLE_CYCLES - 1)) begin
				regulator_off_out   <= 1'b1;
				low_side_ground_out <= 1'b1;
			end else begin
				settle_q <= settle_q + 12'h001;
			end
		end
	end

endmodule

// file: logic/otp_parameter_store.sv
/*
 * One-time-programmable parameter store: fuse programming with locks,
 * read-back with bank redirection, power-up copy into RAM parameters,
 * RAM overwrite by motion configuration, and field decoding.
 * Assumes the bus frame layer delivers decoded commands as one-cycle
 * valid strobes synchronous to clk_in.
 */
// Notes on behaviour
// - unzapped fuses read zero; zapping sets permanently
// - never pulse a bit already at one
// - one fuse byte per program command
// - global lock blocks zapping of all bytes
// - factory lock protects trim bits in bytes 0,1,8
// - unlocked zero bits stay zappable later
// - trim bytes and factory lock preset at delivery; FACTORY_IMAGE presets only the factory lock, trim bytes zero
// - new fuses take effect after power cycle
// - config write overwrites RAM except node bits
// - node bits plus straps form seven-bit address
// - secure position eleven bits, two low zero
// - special pattern disables secure positioning
// - bank select picks bytes 5,6 or 8,9
// - bank select redirects reads of 5,6 to 8,9
// - run current index selects one of sixteen
// - stopped motor drops to hold current
// - hold 1111 drops, then regulator off
// - step field selects half to sixteenth stepping
// - stall threshold zero disables motion detection
// - undervolt field selects one of eight pairs
// - direction bit selects rotation sense
// - power-up loads RAM from fuse contents
`timescale 1ns/1ps
module otp_parameter_store #(
	parameter int ZAP_PULSE_CYCLES = otp_store_pkg::ZAP_CYCLES,
	parameter int SETTLE_CYCLES    = otp_store_pkg::HOLD_SETTLE_CYC
) (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         resetn_in,
	// fuse byte program command
	input  wire logic                         prog_valid_in,
	input  wire otp_store_pkg::fuse_req_type  prog_req_in,
	output logic                              prog_busy_out,
	output logic                              prog_done_out,
	output logic                              prog_blocked_out,
	// fuse byte read command
	input  wire logic                         rd_valid_in,
	input  wire logic [3:0]                   rd_addr_in,
	output logic                              rd_valid_out,
	output logic [7:0]                        rd_data_out,
	// motion configuration write command
	input  wire logic                         cfg_valid_in,
	input  wire otp_store_pkg::motion_cfg_type cfg_in,
	// system inputs
	input  wire logic [2:0]                   pin_strap_bits_in,
	input  wire logic                         motion_running_in,
	// parameters in use
	output logic                              ready_out,
	output otp_store_pkg::motion_cfg_type     params_out,
	output otp_store_pkg::trim_type           trims_out,
	output logic [6:0]                        node_address_out,
	// decoded controls
	output logic                              safe_pos_disabled_out,
	output logic                              stall_detect_en_out,
	output logic [4:0]                        microsteps_out,
	output logic                              dir_ccw_out,
	output logic [3:0]                        coil_level_out,
	output logic                              regulator_off_out,
	output logic                              low_side_ground_out
);
	import otp_store_pkg::*;

	typedef enum logic [2:0] {
		ST_LOAD = 3'b001,
		ST_IDLE = 3'b010,
		ST_ZAP  = 3'b100
	} state_type;

	state_type        state_q;
	logic [11:0]      zap_cnt_q;
	logic [3:0]       zap_addr_q;
	logic [7:0]       zap_mask_q;
	logic             zap_fire;
	logic [FUSE_BITS-1:0] image;
	logic [7:0]       cur_byte;
	logic [7:0]       burn_mask;
	logic [7:0]       wanted;
	logic [3:0]       node_bits_q;
	logic             cmd_ok;

	function automatic logic [7:0] byte_of(input logic [FUSE_BITS-1:0] img,
			input logic [3:0] idx);
		byte_of = 8'h00;
		for (int i = 0; i < FUSE_BYTES; i++) begin
			if (idx == 4'(i)) begin
				byte_of = img[i*FUSE_WIDTH +: FUSE_WIDTH];
			end
		end
	endfunction

	// lock-aware set of bits that may actually be burned
	function automatic logic [7:0] zap_mask(input logic [3:0] addr,
			input logic [7:0] data, input logic [7:0] cur,
			input logic trim_lock, input logic global_lock);
		logic [7:0] m;
		m = data & ~cur;
		if (global_lock) begin
			m = 8'h00;
		end else if (trim_lock) begin
			if (addr == OTP_CALIB_TRIM_A) begin
				m = m & TRIM_LOCK_KEEP_0;
			end else if (addr == OTP_BUS_CONFIG_TRIM) begin
				m = m & TRIM_LOCK_KEEP_1;
			end else if (addr == OTP_ALT_SAFE_POS_HI_CLK) begin
				m = m & TRIM_LOCK_KEEP_8;
			end
		end
		zap_mask = m;
	endfunction

	function automatic logic [6:0] node_combine(input logic sel,
			input logic [3:0] phys, input logic [2:0] strap);
		if (sel) begin
			node_combine = {strap, phys};
		end else begin
			node_combine = {phys, strap};
		end
	endfunction

	fuse_array #(
		.BYTES (FUSE_BYTES),
		.WIDTH (FUSE_WIDTH)
	) u_fuses (
		.clk_in      (clk_in),
		.zap_in      (zap_fire),
		.zap_addr_in (zap_addr_q),
		.zap_mask_in (zap_mask_q),
		.image_out   (image)
	);

	// live fuse view for locks and read-back
	logic [7:0] b0;
	logic [7:0] b1;
	logic [7:0] b2;
	logic [7:0] b3;
	logic [7:0] b4;
	logic [7:0] b5;
	logic [7:0] b7;
	logic [7:0] b8;
	logic [7:0] pos_hi;
	logic [7:0] pos_lo;
	logic       bank_sel;
	logic       trim_lock;
	logic       global_lock;

	always_comb begin
		b0          = byte_of(image, OTP_CALIB_TRIM_A);
		b1          = byte_of(image, OTP_BUS_CONFIG_TRIM);
		b2          = byte_of(image, OTP_STALL_NODE_CFG);
		b3          = byte_of(image, OTP_COIL_CURRENT_CFG);
		b4          = byte_of(image, OTP_SPEED_CFG);
		b5          = byte_of(image, OTP_SAFE_POS_HI_RAMP);
		b7          = byte_of(image, OTP_UNDERVOLT_STEP_LOCK);
		b8          = byte_of(image, OTP_ALT_SAFE_POS_HI_CLK);
		bank_sel    = b0[BANK_SEL_BIT];
		trim_lock   = b7[TRIM_LOCK_BIT];
		global_lock = b7[GLOBAL_LOCK_BIT];
		if (bank_sel) begin
			pos_hi = b8;
			pos_lo = byte_of(image, OTP_ALT_SAFE_POS_LO_FLAGS);
		end else begin
			pos_hi = b5;
			pos_lo = byte_of(image, OTP_SAFE_POS_LO_FLAGS);
		end
	end

	always_comb begin
		cur_byte  = byte_of(image, prog_req_in.addr);
		wanted    = prog_req_in.data & ~cur_byte;
		burn_mask = zap_mask(prog_req_in.addr, prog_req_in.data, cur_byte,
			trim_lock, global_lock);
		cmd_ok    = int'(prog_req_in.addr) < FUSE_BYTES;
		zap_fire  = (state_q == ST_ZAP) && (zap_cnt_q == 12'h000);
	end

	// program sequencer: one byte per accepted command
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			state_q    <= ST_LOAD;
			zap_cnt_q  <= 12'h000;
			zap_addr_q <= 4'h0;
			zap_mask_q <= 8'h00;
		end else begin
			case (state_q)
				ST_LOAD: begin
					state_q <= ST_IDLE;
				end
				ST_IDLE: begin
					if (prog_valid_in && cmd_ok && (burn_mask != 8'h00)) begin
						state_q    <= ST_ZAP;
						zap_addr_q <= prog_req_in.addr;
						zap_mask_q <= burn_mask;
						zap_cnt_q  <= 12'(ZAP_PULSE_CYCLES - 1);
					end
				end
				ST_ZAP: begin
					if (zap_cnt_q == 12'h000) begin
						state_q    <= ST_IDLE;
						zap_mask_q <= 8'h00;
					end else begin
						zap_cnt_q <= zap_cnt_q - 12'h001;
					end
				end
				default: begin
					state_q <= ST_LOAD;
				end
			endcase
		end
	end

	// program status
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			prog_busy_out    <= 1'b1;
			prog_done_out    <= 1'b0;
			prog_blocked_out <= 1'b0;
		end else begin
			prog_done_out <= 1'b0;
			case (state_q)
				ST_LOAD: begin
					prog_busy_out <= 1'b0;
				end
				ST_IDLE: begin
					if (prog_valid_in) begin
						prog_blocked_out <= !cmd_ok || (wanted != burn_mask);
						if (cmd_ok && (burn_mask != 8'h00)) begin
							prog_busy_out <= 1'b1;
						end else begin
							prog_done_out <= 1'b1;
						end
					end
				end
				ST_ZAP: begin
					if (zap_cnt_q == 12'h000) begin
						prog_busy_out <= 1'b0;
						prog_done_out <= 1'b1;
					end
				end
				default: begin
					prog_busy_out <= 1'b1;
				end
			endcase
		end
	end

	// read-back of the live fuses
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			rd_valid_out <= 1'b0;
			rd_data_out  <= 8'h00;
		end else begin
			rd_valid_out <= rd_valid_in;
			if (rd_valid_in) begin
				if (bank_sel && (rd_addr_in == OTP_SAFE_POS_HI_RAMP)) begin
					rd_data_out <= b8;
				end else if (bank_sel &&
						(rd_addr_in == OTP_SAFE_POS_LO_FLAGS)) begin
					rd_data_out <= byte_of(image,
						OTP_ALT_SAFE_POS_LO_FLAGS);
				end else begin
					rd_data_out <= byte_of(image, rd_addr_in);
				end
			end
		end
	end

	// RAM parameters: copied once after reset, then only by config writes
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			params_out  <= '0;
			trims_out   <= '0;
			node_bits_q <= 4'h0;
			ready_out   <= 1'b0;
		end else if (state_q == ST_LOAD) begin
			ready_out                            <= 1'b1;
			params_out.stall_emf_threshold       <= b2[STALL_LSB +: 4];
			params_out.run_current               <= b3[RUN_LSB +: 4];
			params_out.hold_current              <= b3[HOLD_LSB +: 4];
			params_out.max_velocity              <= b4[VMAX_LSB +: 4];
			params_out.min_velocity              <= b4[VMIN_LSB +: 4];
			// shaft and accel stay in byte five whatever the bank
			params_out.shaft_dir                 <= b5[SHAFT_BIT];
			params_out.accel                     <= b5[ACC_LSB +: 4];
			params_out.safe_target_position      <= {pos_hi[SAFE_HI_LSB +: 3],
				pos_lo[SAFE_LO_LSB +: 6], 2'b00};
			params_out.fail_safe                 <= pos_lo[FAILSAFE_BIT];
			params_out.auto_sleep_allow          <= pos_lo[SLEEP_BIT];
			params_out.microstep_resolution      <= b7[STEP_LSB +: 2];
			params_out.undervolt_level_sel       <= b7[UV_LEVEL_LSB +: 3];
			params_out.undervolt_recover_filter  <= b7[UV_FILTER_BIT];
			trims_out.thermal_trip_trim          <= b0[THERMAL_LSB +: 3];
			trims_out.current_reference_trim     <= b0[CURREF_LSB +: 4];
			trims_out.bandgap_trim               <= b1[BANDGAP_LSB +: 6];
			trims_out.bus_baud_select            <= b1[BAUD_BIT];
			trims_out.node_id_combine_sel        <= b1[COMBINE_BIT];
			trims_out.clock_trim                 <= b8[CLOCK_TRIM_LSB +: 5];
			node_bits_q                          <= b2[NODE_LSB +: 4];
		end else if (cfg_valid_in) begin
			params_out <= cfg_in;
		end
	end

	// node address from stored node bits and pin straps
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			node_address_out <= 7'h00;
		end else begin
			node_address_out <= node_combine(trims_out.node_id_combine_sel,
				node_bits_q, pin_strap_bits_in);
		end
	end

	// decoded controls from the RAM parameters
	always_ff @(posedge clk_in) begin
		if (!resetn_in) begin
			safe_pos_disabled_out <= 1'b0;
			stall_detect_en_out   <= 1'b0;
			microsteps_out        <= MICROSTEP_BASE;
			dir_ccw_out           <= 1'b0;
		end else begin
			safe_pos_disabled_out <= params_out.safe_target_position[10:2]
				== SAFE_POS_OFF_PATTERN;
			stall_detect_en_out   <= params_out.stall_emf_threshold
				!= 4'h0;
			microsteps_out        <= MICROSTEP_BASE
				<< params_out.microstep_resolution;
			dir_ccw_out           <= params_out.shaft_dir;
		end
	end

	// run and hold level sequencing; run index 0 lowest, 15 highest
	current_hold_seq #(
		.SETTLE_CYCLES (SETTLE_CYCLES)
	) u_hold (
		.clk_in              (clk_in),
		.resetn_in           (resetn_in),
		.running_in          (motion_running_in),
		.run_idx_in          (params_out.run_current),
		.hold_idx_in         (params_out.hold_current),
		.level_out           (coil_level_out),
		.regulator_off_out   (regulator_off_out),
		.low_side_ground_out (low_side_ground_out)
	);

endmodule

// file: tb/otp_store_assertions.sv
/* Checker for otp_parameter_store: program, read, config and decode timing.
   Bound to the top module; sees only its ports. */
`timescale 1ns/1ps
module otp_store_assertions #(
	parameter int ZAP_PULSE_CYCLES = otp_store_pkg::ZAP_CYCLES
) (
	// clock and reset
	input wire logic                           clk_in,
	input wire logic                           resetn_in,
	// commands
	input wire logic                           prog_busy_out,
	input wire logic                           prog_done_out,
	input wire logic                           rd_valid_in,
	input wire logic                           rd_valid_out,
	input wire logic                           cfg_valid_in,
	input wire otp_store_pkg::motion_cfg_type  cfg_in,
	input wire logic                           motion_running_in,
	// parameters and decodes
	input wire logic                           ready_out,
	input wire otp_store_pkg::motion_cfg_type  params_out,
	input wire logic                           safe_pos_disabled_out,
	input wire logic                           stall_detect_en_out,
	input wire logic [4:0]                     microsteps_out,
	input wire logic                           dir_ccw_out,
	input wire logic [3:0]                     coil_level_out,
	input wire logic                           regulator_off_out,
	input wire logic                           low_side_ground_out
);
	import otp_store_pkg::*;
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);
	logic [7:0] busy_n_q;
	always_ff @(posedge clk_in) begin
		if (!resetn_in || !prog_busy_out)
			busy_n_q <= 8'h00;
		else
			busy_n_q <= busy_n_q + 8'h01;
	end
	sequence stopped_at_zero;
		(!motion_running_in && params_out.hold_current == HOLD_ZERO_INDEX)[*8];
	endsequence
	sequence just_stopped;
		$fell(motion_running_in) && params_out.hold_current != HOLD_ZERO_INDEX;
	endsequence
	a_read_answer:
	assert property (rd_valid_in |=> rd_valid_out)
		else $error("read not answered");
	a_zap_length:
	assert property ($fell(prog_busy_out) && $past(resetn_in, 2) |->
		prog_done_out && busy_n_q == ZAP_PULSE_CYCLES)
		else $error("zap length wrong");
	a_ready_load:
	assert property ($rose(resetn_in) |-> ##1 ready_out && !prog_busy_out)
		else $error("load not done");
	a_cfg_params:
	assert property (cfg_valid_in && ready_out |=> params_out == $past(cfg_in))
		else $error("config not applied");
	a_step_decode:
	assert property (microsteps_out ==
		(MICROSTEP_BASE << $past(params_out.microstep_resolution)))
		else $error("step decode wrong");
	a_stall_decode:
	assert property (stall_detect_en_out ==
		($past(params_out.stall_emf_threshold) != 4'h0))
		else $error("stall enable wrong");
	a_dir_decode:
	assert property (dir_ccw_out == $past(params_out.shaft_dir))
		else $error("direction wrong");
	a_safe_off:
	assert property (safe_pos_disabled_out == ($past(
		params_out.safe_target_position[10:2]) == SAFE_POS_OFF_PATTERN))
		else $error("safe disable wrong");
	a_run_level:
	assert property (motion_running_in && ready_out |=>
		coil_level_out == $past(params_out.run_current) && !regulator_off_out)
		else $error("run level wrong");
	a_hold_level:
	assert property (just_stopped |=>
		coil_level_out == $past(params_out.hold_current))
		else $error("hold level wrong");
	a_hold_zero:
	assert property (stopped_at_zero |-> coil_level_out ==
		LOWEST_LEVEL_INDEX && regulator_off_out && low_side_ground_out)
		else $error("zero hold not applied");
endmodule
bind otp_parameter_store otp_store_assertions #(
	.ZAP_PULSE_CYCLES(ZAP_PULSE_CYCLES)
) chk (.*);

// file: tb/lin_master_model.sv
/* Bus master model: issues program, read and config commands.
   Assumes its tasks are called one at a time from the bench. */
`timescale 1ns/1ps
module lin_master_model (
	// clock
	input  wire logic                     clk_in,
	// program
	output otp_store_pkg::fuse_req_type   prog_req_out,
	output logic                          prog_valid_out,
	input  wire logic                     prog_done_in,
	input  wire logic                     prog_blocked_in,
	// read and config
	output logic                          rd_valid_out,
	output logic [3:0]                    rd_addr_out,
	output logic                          cfg_valid_out,
	output otp_store_pkg::motion_cfg_type cfg_out
);
	import otp_store_pkg::*;
	logic [7:0] exp_q[$];
	initial begin
		prog_valid_out = 1'b0;
		rd_valid_out = 1'b0;
		cfg_valid_out = 1'b0;
		prog_req_out = '0;
		rd_addr_out = 4'h0;
		cfg_out = '0;
	end
	// one byte per command, next only after done
	task automatic prog(input logic [3:0] a, input logic [7:0] d,
		output logic blk, output logic ok);
		@(negedge clk_in);
		prog_valid_out = 1'b1;
		prog_req_out = {a, d};
		ok = 1'b0;
		for (int i = 0; i < 200 && !ok; i++) begin
			@(negedge clk_in);
			prog_valid_out = 1'b0; // done may stand in the first cycle
			ok = (prog_done_in === 1'b1);
		end
		blk = prog_blocked_in;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(negedge clk_in);
		rd_valid_out = 1'b1;
		rd_addr_out = a;
		exp_q.push_back(e);
		@(negedge clk_in);
		rd_valid_out = 1'b0;
		rd_addr_out = ~a;
	endtask
	task automatic cfg(input motion_cfg_type c);
		@(negedge clk_in);
		cfg_valid_out = 1'b1;
		cfg_out = c;
		@(negedge clk_in);
		cfg_valid_out = 1'b0;
		cfg_out = ~c;
	endtask
endmodule

// file: tb/tb_top.sv
/* Bench for otp_parameter_store: burns, locks, bank redirect, power
   cycle, config overwrite, decodes, hold current. Needs the model. */
`timescale 1ns/1ps
module tb_top;
	import otp_store_pkg::*;
	logic clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [2:0] pin_strap_bits_in = 3'h0;
	logic motion_running_in = 1'b0;
	logic prog_valid_in, rd_valid_in, cfg_valid_in;
	fuse_req_type prog_req_in;
	logic [3:0] rd_addr_in, coil_level_out;
	motion_cfg_type cfg_in, params_out;
	trim_type trims_out;
	logic prog_busy_out, prog_done_out, prog_blocked_out, rd_valid_out;
	logic ready_out, safe_pos_disabled_out, stall_detect_en_out;
	logic dir_ccw_out, regulator_off_out, low_side_ground_out;
	logic [7:0] rd_data_out;
	logic [6:0] node_address_out;
	logic [4:0] microsteps_out;
	logic [7:0] fz [10];
	int n_mismatch = 0;
	int samples_checked = 0;
	always #12.5 clk_in = ~clk_in;
	otp_parameter_store #(.ZAP_PULSE_CYCLES(4), .SETTLE_CYCLES(3)) dut (.*);
	lin_master_model m (.clk_in(clk_in), .prog_req_out(prog_req_in),
		.prog_valid_out(prog_valid_in), .prog_done_in(prog_done_out),
		.prog_blocked_in(prog_blocked_out), .rd_valid_out(rd_valid_in),
		.rd_addr_out(rd_addr_in), .cfg_valid_out(cfg_valid_in),
		.cfg_out(cfg_in));
	task automatic check(string w, logic [63:0] s, logic [63:0] e);
		samples_checked++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic results();
		if (n_mismatch == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	function automatic logic [7:0] keep(logic [3:0] a);
		if (fz[7][GLOBAL_LOCK_BIT]) return 8'h00;
		if (!fz[7][TRIM_LOCK_BIT]) return 8'hff;
		case (a)
			4'h0: return TRIM_LOCK_KEEP_0;
			4'h1: return TRIM_LOCK_KEEP_1;
			4'h8: return TRIM_LOCK_KEEP_8;
			default: return 8'hff;
		endcase
	endfunction
	function automatic logic [7:0] fuse_rd(logic [3:0] a);
		if (a > 4'h9) return 8'h00;
		if (fz[0][BANK_SEL_BIT] && (a == 4'h5 || a == 4'h6))
			return fz[a + 4'h3];
		return fz[a];
	endfunction
	task automatic burn(logic [3:0] a, logic [7:0] d);
		logic eb, b, ok;
		logic [7:0] k;
		eb = (a > 4'h9);
		if (!eb) begin
			k = keep(a);
			eb = |(d & ~fz[a] & ~k);
			fz[a] = fz[a] | (d & k);
		end
		m.prog(a, d, b, ok);
		check("prog done", ok, 1'b1);
		check("prog blocked", b, eb);
		m.rd(a, fuse_rd(a));
	endtask
	task automatic power_cycle();
		repeat (2) @(negedge clk_in);
		resetn_in = 1'b0;
		repeat (12) @(negedge clk_in);
		resetn_in = 1'b1;
		repeat (3) @(negedge clk_in);
	endtask
	always @(negedge clk_in) begin
		if (rd_valid_out === 1'b1) begin
			if (m.exp_q.size() == 0)
				check("read extra", 1'b1, 1'b0);
			else
				check("read data", rd_data_out, m.exp_q.pop_front());
		end
	end
	initial begin
		#(25 * 6000);
		n_mismatch++;
		results();
	end
	initial begin
		logic [63:0] r;
		motion_cfg_type c;
		r = $urandom(7);
		for (int i = 0; i < 10; i++) fz[i] = FACTORY_IMAGE[i*8 +: 8];
		r = {$urandom, $urandom};
		pin_strap_bits_in = r[2:0];
		power_cycle();
		check("ready", ready_out, 1'b1);
		for (int a = 0; a < 11; a++) m.rd(4'(a), fuse_rd(4'(a)));
		burn(4'h5, r[15:8]);
		burn(4'h5, 8'hff);
		burn(4'h2, r[23:16]);
		burn(4'h9, r[31:24]);
		burn(4'h1, 8'hff);
		burn(4'h8, 8'hff);
		burn(4'h0, 8'hff);
		burn(4'hc, 8'hff);
		m.rd(4'h6, fuse_rd(4'h6));
		check("old stall", params_out.stall_emf_threshold, 4'h0);
		check("old node", node_address_out, {4'h0, pin_strap_bits_in});
		power_cycle();
		check("safe pos", params_out.safe_target_position,
			{fz[8][7:5], fz[9][7:2], 2'b00});
		check("fail safe", params_out.fail_safe, fz[9][FAILSAFE_BIT]);
		check("sleep", params_out.auto_sleep_allow, fz[9][SLEEP_BIT]);
		check("node", node_address_out, {pin_strap_bits_in, fz[2][3:0]});
		check("stall", params_out.stall_emf_threshold, fz[2][7:4]);
		check("baud", trims_out.bus_baud_select, 1'b1);
		check("shaft", params_out.shaft_dir, fz[5][SHAFT_BIT]);
		burn(4'h7, 8'h01);
		burn(4'h3, 8'hff);
		for (int i = 0; i < 4; i++) begin
			r = {$urandom, $urandom};
			c = r[$bits(c)-1:0];
			c.microstep_resolution = 2'(i);
			if (i == 0) c.safe_target_position[10:2] = SAFE_POS_OFF_PATTERN;
			if (i == 1) c.stall_emf_threshold = 4'h0;
			m.cfg(c);
			repeat (2) @(negedge clk_in);
			check("params", params_out, c);
			check("steps", microsteps_out, MICROSTEP_BASE << i);
			check("stall en", stall_detect_en_out, |c.stall_emf_threshold);
			check("dir", dir_ccw_out, c.shaft_dir);
			check("safe off", safe_pos_disabled_out,
				c.safe_target_position[10:2] == SAFE_POS_OFF_PATTERN);
			check("node kept", node_address_out,
				{pin_strap_bits_in, fz[2][3:0]});
		end
		c.hold_current = HOLD_ZERO_INDEX;
		m.cfg(c);
		motion_running_in = 1'b1;
		repeat (4) @(negedge clk_in);
		check("run level", coil_level_out, c.run_current);
		motion_running_in = 1'b0;
		repeat (12) @(negedge clk_in);
		check("zero hold", {coil_level_out, regulator_off_out,
			low_side_ground_out}, {4'h0, 2'b11});
		c.hold_current = 4'(r[3:0] % 15);
		m.cfg(c);
		motion_running_in = 1'b1;
		repeat (4) @(negedge clk_in);
		motion_running_in = 1'b0;
		repeat (4) @(negedge clk_in);
		check("hold level", {coil_level_out, regulator_off_out},
			{c.hold_current, 1'b0});
		check("reads left", m.exp_q.size(), 0);
		results();
	end
endmodule
